// file: rtl/channel_defines.vh
`ifndef CHANNEL_DEFINES_VH
`define CHANNEL_DEFINES_VH

// ==========================================
// Register byte addresses
`define A_CTRL 8'h00
`define A_TRIG 8'h04
`define A_PERIOD 8'h08
`define A_STATUS 8'h0c
`define A_COUNT 8'h10
`define A_HITS 8'h14

// ==========================================
// Field positions
`define F_THR1 0
`define F_THR2 6
`define F_BASE 12
`define F_T2FALL 18
`define F_CNTEN 19
`define F_DLY 0
`define F_LUT 8
`define F_ST_BUF 0
`define F_ST_PEND 4
`define F_ST_CHAN 12
`define F_ST_CC 16

// ==========================================
// Reset values
`define RST_THR1 6'h08
`define RST_THR2 6'h10
`define RST_BASE 6'h20
`define RST_DLY 4'h2
`define RST_LUT 8'h80
`define RST_PERIOD 24'hffffff

// ==========================================
// Widths and sizes
`define COARSE_W 16
`define CNT_W 24
`define ADC_W 10
`define NBUF 6
`define FINE_LSB_PS 20
`define ADC_RATE_MHZ 40

// ==========================================
// Timing
`define CLK_NS 50
`define REARM_MAX_NS 25
`define REARM_CYC ((`REARM_MAX_NS / `CLK_NS) < 1 ? 1 : (`REARM_MAX_NS / `CLK_NS))
`define IDLE_US 100
`define IDLE_CYC ((`IDLE_US * 1000) / `CLK_NS)
`define RAMP_EDGES 2
`define INTEG_CYC 4
`define ACQ_LIMIT 32

`endif

// file: rtl/hit_store.v
`timescale 1ns/100ps
module hit_store #(
  parameter W = 48,
  parameter D = 6,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output wire [W-1:0] rdata
);

  reg [W-1:0] mem [0:D-1];
  reg [W-1:0] rdata_ff;

  assign rdata = rdata_ff;

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read follows the address one cycle later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= {W{1'b0}};
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule

// file: rtl/sipm_channel_digitization_control.v
`timescale 1ns/100ps
`include "channel_defines.vh"
module sipm_channel_digitization_control (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Discriminators, asynchronous
  input wire first_timing_discriminator,
  input wire second_timing_discriminator,
  input wire energy_discriminator,
  // Analog settings and switches
  output wire [5:0] first_timing_threshold,
  output wire [5:0] second_timing_threshold,
  output wire [5:0] baseline_offset,
  output wire time_ramp_switch,
  output wire second_ramp_switch,
  output wire integration_switch,
  output wire [2:0] buffer_set_index,
  // Shared converter
  output wire adc_req,
  output wire [1:0] adc_sel,
  output wire [2:0] adc_buf,
  input wire adc_done,
  input wire [9:0] adc_data,
  // Hit record
  output wire hit_valid,
  output wire [2:0] hit_buf,
  output wire [9:0] hit_t1_fine,
  output wire [9:0] hit_t2_fine,
  output wire [9:0] hit_charge,
  output wire [15:0] hit_t1_coarse,
  output wire [15:0] hit_t2_coarse,
  output wire [15:0] hit_q_coarse,
  // Event counter
  output wire [23:0] evt_count,
  output wire evt_count_valid
);

  // ==========================================
  // Constants
  localparam S_READY = 3'b001;
  localparam S_ACQ = 3'b010;
  localparam S_REARM = 3'b100;
  localparam C_IDLE = 4'b0001;
  localparam C_REQ = 4'b0010;
  localparam C_GAP = 4'b0100;
  localparam C_EMIT = 4'b1000;
  localparam [10:0] IDLE_LAST = `IDLE_CYC - 1;
  localparam [5:0] ACQ_LAST = `ACQ_LIMIT - 1;
  localparam [2:0] BUF_LAST = `NBUF - 1;

  function rise;
    input cur;
    input prev;
    begin
      rise = cur & ~prev;
    end
  endfunction

  function [2:0] next_buf;
    input [2:0] b;
    begin
      next_buf = (b == BUF_LAST) ? 3'h0 : b + 3'h1;
    end
  endfunction

  // ==========================================
  // Configuration and status registers
  reg [5:0] thr1_ff, thr2_ff, base_ff;
  reg t2fall_ff, cnten_ff;
  reg [3:0] dly_cfg_ff;
  reg [7:0] lut_ff;
  reg [23:0] period_ff;
  reg [31:0] prdata_ff;
  reg pready_ff, pslverr_ff;
  reg [15:0] hits_ff;
  reg [15:0] cc_ff;
  reg [2:0] st_ff, buf_ff, cbuf_ff;
  reg [5:0] pend_ff;
  reg [23:0] cnt_res_ff;

  wire acc = psel & penable;
  wire mapped = (paddr == `A_CTRL) | (paddr == `A_TRIG) | (paddr == `A_PERIOD) |
    (paddr == `A_STATUS) | (paddr == `A_COUNT) | (paddr == `A_HITS);
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `A_CTRL: rd_mux = {12'h000, cnten_ff, t2fall_ff, base_ff, thr2_ff, thr1_ff};
      `A_TRIG: rd_mux = {16'h0000, lut_ff, 4'h0, dly_cfg_ff};
      `A_PERIOD: rd_mux = {8'h00, period_ff};
      `A_STATUS: rd_mux = {cc_ff, 1'b0, st_ff, 2'h0, pend_ff, 1'b0, buf_ff};
      `A_COUNT: rd_mux = {8'h00, cnt_res_ff};
      `A_HITS: rd_mux = {16'h0000, hits_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer in the second access cycle; writes land on the completing edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      thr1_ff <= `RST_THR1;
      thr2_ff <= `RST_THR2;
      base_ff <= `RST_BASE;
      t2fall_ff <= 1'b0;
      cnten_ff <= 1'b0;
      dly_cfg_ff <= `RST_DLY;
      lut_ff <= `RST_LUT;
      period_ff <= `RST_PERIOD;
    end else begin
      pready_ff <= acc & ~pready_ff;
      if (acc & ~pready_ff) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_ff <= ~mapped;
      end
      if (acc & pready_ff & pwrite) begin
        case (paddr)
          `A_CTRL: begin
            thr1_ff <= pwdata[`F_THR1 +: 6];
            thr2_ff <= pwdata[`F_THR2 +: 6];
            base_ff <= pwdata[`F_BASE +: 6];
            t2fall_ff <= pwdata[`F_T2FALL];
            cnten_ff <= pwdata[`F_CNTEN];
          end
          `A_TRIG: begin
            dly_cfg_ff <= pwdata[`F_DLY +: 4];
            lut_ff <= pwdata[`F_LUT +: 8];
          end
          `A_PERIOD: period_ff <= pwdata[23:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // Input synchronisers and trigger derivation
  reg [3:0] s1_ff, s2_ff, prev_ff;
  reg [15:0] dly_ff;
  reg trig1_d_ff;
  wire trig1;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      prev_ff <= 4'h0;
      dly_ff <= 16'h0000;
      trig1_d_ff <= 1'b0;
      cc_ff <= 16'h0000;
    end else begin
      s1_ff <= {adc_done, energy_discriminator, second_timing_discriminator, first_timing_discriminator};
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
      dly_ff <= {dly_ff[14:0], s2_ff[0]};
      trig1_d_ff <= trig1;
      cc_ff <= cc_ff + 16'h0001;
    end
  end

  wire t2_s = s2_ff[1];
  wire e_s = s2_ff[2];
  wire done_s = s2_ff[3];
  assign trig1 = (dly_cfg_ff == 4'h0) ? s2_ff[0] : dly_ff[dly_cfg_ff - 4'h1];
  wire t2_rise = rise(t2_s, prev_ff[1]);
  wire t2_fall = rise(~t2_s, ~prev_ff[1]);

  // ==========================================
  // Ramp and integration sequencers
  wire arm = st_ff[0] | st_ff[1];
  wire acq_end;
  wire [2:0] ph_start, ph_sw, ph_done;
  wire [47:0] ph_coarse;
  wire ph_clr = acq_end | st_ff[2];

  assign ph_start[0] = arm & rise(trig1, trig1_d_ff);
  assign ph_start[1] = arm & (t2fall_ff ? t2_fall : t2_rise);
  assign ph_start[2] = arm & t2_rise;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ph
      localparam [2:0] LAST = (g == 2) ? `INTEG_CYC - 1 : `RAMP_EDGES - 1;
      reg sw_ff, lat_ff, done_ff;
      reg [2:0] cnt_ff;
      reg [15:0] coarse_ff;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sw_ff <= 1'b0;
          lat_ff <= 1'b0;
          done_ff <= 1'b0;
          cnt_ff <= 3'h0;
          coarse_ff <= 16'h0000;
        end else if (ph_clr) begin
          sw_ff <= 1'b0;
          lat_ff <= 1'b0;
          done_ff <= 1'b0;
          cnt_ff <= 3'h0;
        end else if (sw_ff) begin
          // Opens on the edge where the count is reached
          if (cnt_ff == LAST) begin
            sw_ff <= 1'b0;
            lat_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff + 3'h1;
          end
        end else if (lat_ff) begin
          coarse_ff <= cc_ff;
          lat_ff <= 1'b0;
          done_ff <= 1'b1;
        end else if (ph_start[g] & ~done_ff) begin
          sw_ff <= 1'b1;
          cnt_ff <= 3'h0;
        end
      end
      assign ph_sw[g] = sw_ff;
      assign ph_done[g] = done_ff;
      assign ph_coarse[g*16 +: 16] = coarse_ff;
    end
  endgenerate

  assign time_ramp_switch = ph_sw[0];
  assign second_ramp_switch = ph_sw[1];
  assign integration_switch = ph_sw[2];

  // ==========================================
  // Channel state machine
  reg seen_t2_ff, seen_e_ff;
  reg [10:0] idle_ff;
  reg [5:0] acq_cnt_ff;

  wire acq_timeout = st_ff[1] & (acq_cnt_ff == ACQ_LAST);
  wire acq_drop = st_ff[1] & ~seen_t2_ff & ~t2_rise & ph_done[0];
  wire acq_full = st_ff[1] & (ph_done == 3'b111);
  assign acq_end = acq_drop | acq_full | acq_timeout;
  wire acq_valid = acq_full & ~acq_drop & (seen_e_ff | e_s);
  wire [2:0] buf_nxt = next_buf(buf_ff);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_READY;
      buf_ff <= 3'h0;
      seen_t2_ff <= 1'b0;
      seen_e_ff <= 1'b0;
      idle_ff <= 11'h000;
      acq_cnt_ff <= 6'h00;
    end else begin
      case (st_ff)
        S_READY: begin
          seen_t2_ff <= t2_rise;
          seen_e_ff <= e_s;
          acq_cnt_ff <= 6'h00;
          if (|ph_start) begin
            st_ff <= S_ACQ;
            idle_ff <= 11'h000;
          end else if (idle_ff == IDLE_LAST) begin
            st_ff <= S_REARM;
            idle_ff <= 11'h000;
          end else begin
            idle_ff <= idle_ff + 11'h001;
          end
        end
        S_ACQ: begin
          seen_t2_ff <= seen_t2_ff | t2_rise;
          seen_e_ff <= seen_e_ff | e_s;
          acq_cnt_ff <= acq_cnt_ff + 6'h01;
          if (acq_drop) begin
            st_ff <= S_READY;
          end else if (acq_end) begin
            st_ff <= S_REARM;
          end
        end
        S_REARM: begin
          // Waits only while the next set still awaits conversion
          if (~pend_ff[buf_nxt]) begin
            buf_ff <= buf_nxt;
            st_ff <= S_READY;
          end
        end
        default: st_ff <= S_READY;
      endcase
    end
  end

  assign buffer_set_index = buf_ff;

  // ==========================================
  // Stored coarse values per buffer set
  wire [47:0] rd_coarse;

  hit_store #(
    .W(48),
    .D(`NBUF),
    .AW(3)
  ) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .we(acq_valid),
    .waddr(buf_ff),
    .wdata(ph_coarse),
    .raddr(cbuf_ff),
    .rdata(rd_coarse)
  );

  // ==========================================
  // Conversion sequencer for the shared converter
  reg [3:0] cst_ff;
  reg [1:0] sel_ff;
  reg req_ff;
  reg [29:0] res_ff;
  reg hv_ff;
  reg [2:0] hbuf_ff;
  reg [29:0] hfine_ff;
  reg [47:0] hcoarse_ff;
  wire [5:0] pend_set = acq_valid ? (6'h01 << buf_ff) : 6'h00;
  wire [5:0] pend_clr = cst_ff[3] ? (6'h01 << cbuf_ff) : 6'h00;

  generate
    for (g = 0; g < `NBUF; g = g + 1) begin : pend
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_ff[g] <= 1'b0;
        end else begin
          pend_ff[g] <= pend_set[g] | (pend_ff[g] & ~pend_clr[g]);
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cst_ff <= C_IDLE;
      cbuf_ff <= 3'h0;
      sel_ff <= 2'h0;
      req_ff <= 1'b0;
      res_ff <= 30'h0000_0000;
      hv_ff <= 1'b0;
      hbuf_ff <= 3'h0;
      hfine_ff <= 30'h0000_0000;
      hcoarse_ff <= 48'h0000_0000_0000;
      hits_ff <= 16'h0000;
    end else begin
      hv_ff <= 1'b0;
      case (cst_ff)
        C_IDLE: begin
          if (pend_ff[cbuf_ff]) begin
            sel_ff <= 2'h0;
            req_ff <= 1'b1;
            cst_ff <= C_REQ;
          end else if (|pend_ff) begin
            cbuf_ff <= next_buf(cbuf_ff);
          end
        end
        C_REQ: begin
          // Converter holds its code while done stays high
          if (done_s) begin
            case (sel_ff)
              2'h0: res_ff[9:0] <= adc_data;
              2'h1: res_ff[19:10] <= adc_data;
              default: res_ff[29:20] <= adc_data;
            endcase
            req_ff <= 1'b0;
            cst_ff <= C_GAP;
          end
        end
        C_GAP: begin
          if (~done_s) begin
            if (sel_ff == 2'h2) begin
              cst_ff <= C_EMIT;
            end else begin
              sel_ff <= sel_ff + 2'h1;
              req_ff <= 1'b1;
              cst_ff <= C_REQ;
            end
          end
        end
        C_EMIT: begin
          hv_ff <= 1'b1;
          hbuf_ff <= cbuf_ff;
          hfine_ff <= res_ff;
          hcoarse_ff <= rd_coarse;
          hits_ff <= hits_ff + 16'h0001;
          cbuf_ff <= next_buf(cbuf_ff);
          cst_ff <= C_IDLE;
        end
        default: cst_ff <= C_IDLE;
      endcase
    end
  end

  // ==========================================
  // Event counter
  reg comb_d_ff;
  reg [23:0] per_ff, evc_ff;
  reg evv_ff;
  wire comb = lut_ff[s2_ff[2:0]];
  wire comb_rise = rise(comb, comb_d_ff);

  // Period field holds length minus one, so 2^24 cycles fits in 24 bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comb_d_ff <= 1'b0;
      per_ff <= 24'h000000;
      evc_ff <= 24'h000000;
      cnt_res_ff <= 24'h000000;
      evv_ff <= 1'b0;
    end else begin
      comb_d_ff <= comb;
      evv_ff <= 1'b0;
      if (~cnten_ff) begin
        per_ff <= 24'h000000;
        evc_ff <= 24'h000000;
      end else if (per_ff == period_ff) begin
        cnt_res_ff <= evc_ff + {23'h000000, comb_rise};
        evv_ff <= 1'b1;
        per_ff <= 24'h000000;
        evc_ff <= 24'h000000;
      end else begin
        per_ff <= per_ff + 24'h000001;
        evc_ff <= evc_ff + {23'h000000, comb_rise};
      end
    end
  end

  // ==========================================
  // Output wiring
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign first_timing_threshold = thr1_ff;
  assign second_timing_threshold = thr2_ff;
  assign baseline_offset = base_ff;
  assign adc_req = req_ff;
  assign adc_sel = sel_ff;
  assign adc_buf = cbuf_ff;
  assign hit_valid = hv_ff;
  assign hit_buf = hbuf_ff;
  assign hit_t1_fine = hfine_ff[9:0];
  assign hit_t2_fine = hfine_ff[19:10];
  assign hit_charge = hfine_ff[29:20];
  assign hit_t1_coarse = hcoarse_ff[15:0];
  assign hit_t2_coarse = hcoarse_ff[31:16];
  assign hit_q_coarse = hcoarse_ff[47:32];
  assign evt_count = cnt_res_ff;
  assign evt_count_valid = evv_ff;

endmodule

// file: verif/chan_checker_asserts.sv
`timescale 1ns/100ps
module chan_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Channel outputs
  input wire [5:0] first_timing_threshold,
  input wire time_ramp_switch,
  input wire second_ramp_switch,
  input wire integration_switch,
  input wire [2:0] buffer_set_index,
  input wire hit_valid,
  input wire [2:0] hit_buf,
  // Converter
  input wire adc_req,
  input wire adc_done,
  input wire [1:0] adc_sel,
  input wire [2:0] adc_buf
);
  // ==========================================
  // Switch, register, converter and buffer relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ramp_width:
    assert property ($rose(time_ramp_switch) |=> time_ramp_switch ##1 !time_ramp_switch)
    else $error("First ramp width wrong");
  chk_ramp2_width:
    assert property ($rose(second_ramp_switch) |=> second_ramp_switch ##1 !second_ramp_switch)
    else $error("Second ramp width wrong");
  chk_integ_window:
    assert property ($rose(integration_switch) |=> integration_switch [*3] ##1 !integration_switch)
    else $error("Integration window wrong");
  chk_thr_write:
    assert property (psel && penable && pready && pwrite && paddr == 8'h00
      |=> first_timing_threshold == $past(pwdata[5:0]))
    else $error("Threshold not written");
  chk_round_robin:
    assert property (buffer_set_index != $past(buffer_set_index) |-> buffer_set_index ==
      ($past(buffer_set_index) == 3'h5 ? 3'h0 : $past(buffer_set_index) + 3'h1))
    else $error("Buffer set not round robin");
  chk_req_held:
    assert property (adc_req && !adc_done |=> adc_req)
    else $error("Request dropped early");
  chk_req_stable:
    assert property (adc_req && $past(adc_req) |-> $stable(adc_sel) && $stable(adc_buf))
    else $error("Request changed while pending");
  chk_req_gap:
    assert property ($fell(adc_req) |-> !adc_req [*2])
    else $error("Conversions overlap");
  chk_hit_tag:
    assert property (hit_valid |-> hit_buf < 3'h6 ##1 !hit_valid)
    else $error("Hit tag or pulse wrong");
endmodule

bind sipm_channel_digitization_control chan_checker chan_checker_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .first_timing_threshold(first_timing_threshold), .time_ramp_switch(time_ramp_switch),
  .second_ramp_switch(second_ramp_switch), .integration_switch(integration_switch),
  .buffer_set_index(buffer_set_index), .hit_valid(hit_valid), .hit_buf(hit_buf),
  .adc_req(adc_req), .adc_done(adc_done), .adc_sel(adc_sel), .adc_buf(adc_buf));

// file: verif/adc_model.sv
`timescale 1ns/100ps
module adc_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Request
  input wire adc_req,
  input wire [1:0] adc_sel,
  input wire [2:0] adc_buf,
  input wire [3:0] lat,
  // Answer
  output reg adc_done,
  output reg [9:0] adc_data
);
  reg [3:0] wait_ff;
  // ==========================================
  // Conversion
  // Code scrambles while no answer stands, so stale data never matches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_done <= 1'b0;
      wait_ff <= 4'h0;
      adc_data <= 10'h155;
    end else if (!adc_req) begin
      adc_done <= 1'b0;
      wait_ff <= 4'h0;
      adc_data <= ~adc_data;
    end else if (!adc_done) begin
      wait_ff <= wait_ff + 4'h1;
      if (wait_ff >= lat) begin
        adc_done <= 1'b1;
        adc_data <= {adc_buf, adc_sel, 5'h0b};
      end else begin
        adc_data <= ~adc_data;
      end
    end
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  cmp_count = cmp_count + 1; \
  if ((got) !== (exp)) begin \
    n_errors = n_errors + 1; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb;
  reg clk, rst_n, psel, penable, pwrite, rerr, req_q, pulse_on, pulse_t1;
  reg first_timing_discriminator, second_timing_discriminator, energy_discriminator;
  reg [7:0] paddr;
  reg [31:0] pwdata, rdat;
  reg [15:0] lfsr;
  reg [5:0] seq;
  reg [3:0] lat;
  reg [2:0] exp_b, ph;
  integer n_errors, cmp_count, nreq, i, k;
  wire [31:0] prdata;
  wire pready, pslverr, time_ramp_switch, second_ramp_switch, integration_switch;
  wire adc_req, adc_done, hit_valid, evt_count_valid;
  wire [5:0] first_timing_threshold, second_timing_threshold, baseline_offset;
  wire [2:0] buffer_set_index, adc_buf, hit_buf;
  wire [1:0] adc_sel;
  wire [9:0] adc_data, hit_t1_fine, hit_t2_fine, hit_charge;
  wire [15:0] hit_t1_coarse, hit_t2_coarse, hit_q_coarse;
  wire [23:0] evt_count;
  // ==========================================
  // Design and converter model
  sipm_channel_digitization_control sipm_channel_digitization_control_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_timing_discriminator(first_timing_discriminator | pulse_t1),
    .second_timing_discriminator(second_timing_discriminator),
    .energy_discriminator(energy_discriminator),
    .first_timing_threshold(first_timing_threshold), .second_timing_threshold(second_timing_threshold),
    .baseline_offset(baseline_offset), .time_ramp_switch(time_ramp_switch),
    .second_ramp_switch(second_ramp_switch), .integration_switch(integration_switch),
    .buffer_set_index(buffer_set_index), .adc_req(adc_req), .adc_sel(adc_sel), .adc_buf(adc_buf),
    .adc_done(adc_done), .adc_data(adc_data), .hit_valid(hit_valid), .hit_buf(hit_buf),
    .hit_t1_fine(hit_t1_fine), .hit_t2_fine(hit_t2_fine), .hit_charge(hit_charge),
    .hit_t1_coarse(hit_t1_coarse), .hit_t2_coarse(hit_t2_coarse), .hit_q_coarse(hit_q_coarse),
    .evt_count(evt_count), .evt_count_valid(evt_count_valid));
  adc_model adc_model_inst (.clk(clk), .rst_n(rst_n), .adc_req(adc_req), .adc_sel(adc_sel),
    .adc_buf(adc_buf), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));
  // ==========================================
  // Expectations and drivers
  function [15:0] nxt_lfsr(input [15:0] v);
    nxt_lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function [9:0] code(input [1:0] sel, input [2:0] b);
    code = {b, sel, 5'h0b};
  endfunction
  function [2:0] nxt_b(input [2:0] b);
    nxt_b = (b == 3'h5) ? 3'h0 : b + 3'h1;
  endfunction
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
        @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task disc(input a, input b, input c, input integer n);
    begin
      first_timing_discriminator <= a;
      second_timing_discriminator <= b;
      energy_discriminator <= c;
      repeat (n) @(posedge clk);
    end
  endtask
  // Bounded waits; a design that never answers fails at the limit
  task wait_sig(input integer which, input integer lim);
    begin
      k = 0;
      while (k < lim && (which == 0 ? hit_valid !== 1'b1 : which == 1 ? evt_count_valid !== 1'b1
          : buffer_set_index === exp_b)) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= lim) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, k, lim);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    if (adc_req === 1'b1 && req_q !== 1'b1) begin
      seq = {seq[3:0], adc_sel};
      nreq = nreq + 1;
    end
    req_q = adc_req;
    // Own pulse source, ORed in, so the discriminator input keeps one driver
    ph <= pulse_on ? ph + 3'h1 : 3'h0;
    pulse_t1 <= pulse_on & ph[2];
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(20000 * 50);
    n_errors = n_errors + 1;
    finish_test;
  end
  // ==========================================
  // Scenarios
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, lat, seq, exp_b, req_q, pulse_on} = 0;
    {first_timing_discriminator, second_timing_discriminator, energy_discriminator} = 3'h0;
    lfsr = 16'h0041;
    n_errors = 0;
    cmp_count = 0;
    nreq = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    `CHK({first_timing_threshold, second_timing_threshold, baseline_offset}, 18'h08420)
    apb(0, 8'h00, 32'h0);
    `CHK(rdat, 32'h00020408)
    apb(0, 8'h04, 32'h0);
    `CHK(rdat, 32'h00008002)
    apb(0, 8'h18, 32'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    for (i = 0; i < 3; i = i + 1) begin
      lfsr = nxt_lfsr(lfsr);
      apb(1, 8'h00, {14'h0, lfsr[1:0], lfsr});
      `CHK({second_timing_threshold, first_timing_threshold}, lfsr[11:0])
      `CHK(baseline_offset, {lfsr[1:0], lfsr[15:12]})
    end
    $display("Test 1 finished");
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = nxt_lfsr(lfsr);
      // Corner: zero delay takes the undelayed trigger path
      if (i == 0) lfsr[2:0] = 3'h0;
      lat <= lfsr[15:12];
      apb(1, 8'h04, 32'h00008000 | {29'h0, lfsr[2:0]});
      seq = 6'h0;
      disc(1, 1, 1, 8);
      disc(0, 0, 0, 0);
      // Conversion still running here, so the set must already have moved on
      repeat (12) @(posedge clk);
      `CHK(buffer_set_index, nxt_b(exp_b))
      wait_sig(0, 500);
      `CHK(hit_buf, exp_b)
      `CHK(seq, 6'h06)
      `CHK(hit_t1_fine, code(2'h0, exp_b))
      `CHK(hit_t2_fine, code(2'h1, exp_b))
      `CHK(hit_charge, code(2'h2, exp_b))
      `CHK(hit_t1_coarse - hit_t2_coarse, {13'h0, lfsr[2:0]})
      `CHK(hit_q_coarse - hit_t2_coarse, 16'h0002)
      exp_b = nxt_b(exp_b);
      `CHK(buffer_set_index, exp_b)
    end
    $display("Test 2 finished");
    i = nreq;
    disc(1, 0, 0, 3);
    disc(0, 0, 0, 40);
    `CHK(buffer_set_index, exp_b)
    repeat (7) begin
      disc(1, 1, 0, 3);
      disc(0, 0, 0, 40);
      exp_b = nxt_b(exp_b);
      `CHK(buffer_set_index, exp_b)
    end
    `CHK(nreq - i, 0)
    $display("Test 3 finished");
    apb(1, 8'h00, 32'h00040000);
    k = 0;
    disc(1, 1, 1, 0);
    for (i = 0; i < 10; i = i + 1) begin
      @(posedge clk);
      k = k + (second_ramp_switch === 1'b1);
    end
    disc(0, 0, 0, 0);
    for (i = 0; i < 8 && second_ramp_switch !== 1'b1; i = i + 1) @(posedge clk);
    `CHK({k == 0, i < 8}, 2'b11)
    wait_sig(0, 500);
    exp_b = nxt_b(exp_b);
    apb(0, 8'h14, 32'h0);
    `CHK(rdat, 32'h00000005)
    $display("Test 4 finished");
    apb(1, 8'h04, 32'h00000202);
    apb(1, 8'h08, 32'h00000027);
    apb(1, 8'h00, 32'h00080000);
    pulse_on <= 1'b1;
    repeat (2) begin
      @(posedge clk);
      wait_sig(1, 100);
    end
    `CHK(evt_count, 24'h000005)
    apb(0, 8'h10, 32'h0);
    `CHK(rdat, 32'h00000005)
    pulse_on <= 1'b0;
    @(posedge clk);
    first_timing_discriminator <= 1'b0;
    $display("Test 5 finished");
    wait_sig(2, 2100);
    exp_b = nxt_b(exp_b);
    `CHK(buffer_set_index, exp_b)
    wait_sig(2, 2100);
    `CHK(k > 1994 && k < 2006, 1'b1)
    $display("Test 6 finished");
    finish_test;
  end
endmodule
